// ===== cpu_bus_model.sv
// Behavioural CPU side: turns bench cycle requests into core bus signals and counts break requests.
// Assumes requests change just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
   // Clock, reset and bench requests.
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        cycValid,
   input  wire logic [15:0] cycAddr,
   input  wire logic        cycCof,
   // Core side of the design.
   output logic             busValid,
   output logic [15:0]      coreAddr,
   output logic [7:0]       readData,
   output logic             cofDest,
   output logic             execValid,
   output logic [15:0]      execAddr,
   input  wire logic        breakForce,
   input  wire logic        breakTag,
   // Requests honoured so far.
   output int               forceSeen,
   output int               tagSeen
);
   // Opcodes execute two cycles after their fetch, as if they waited in a short queue.
   logic [1:0]       pipeValid;
   logic [1:0][15:0] pipeAddr;
   // Idle cycles invert the bus so that no stale value can still match.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         {busValid, coreAddr, readData, cofDest, execValid, execAddr, pipeValid, pipeAddr} <= '0;
         forceSeen <= 0;
         tagSeen <= 0;
      end else begin
         busValid <= cycValid;
         coreAddr <= cycValid ? cycAddr : ~coreAddr;
         readData <= ~readData;
         cofDest <= cycValid & cycCof;
         pipeValid <= {pipeValid[0], cycValid};
         pipeAddr <= {pipeAddr[0], cycAddr};
         execValid <= pipeValid[1];
         execAddr <= pipeAddr[1];
         forceSeen <= forceSeen + int'(breakForce);
         tagSeen <= tagSeen + int'(breakTag);
      end
   end
endmodule : cpu_bus_model
`default_nettype wire

// ===== trace_trigger_break_control.sv
// Debug comparators, trigger break controller and eight-word trace store for change-of-flow addresses or event data.
// Assumes a CPU on ref_clk presenting its bus cycle, change-of-flow flags and executed opcode address,
// and software on an AXI4-Lite slave port in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "trace_trigger_consts.svh"
module trace_trigger_break_control
   import trace_trigger_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // CPU bus cycle and flow information.
   input  wire logic        busValid,
   input  wire logic        busWrite,
   input  wire logic [15:0] coreAddr,
   input  wire logic [7:0]  readData,
   input  wire logic [7:0]  writeData,
   input  wire logic        cofDest,
   input  wire logic        cofBranch,
   input  wire logic        execValid,
   input  wire logic [15:0] execAddr,
   // Breakpoint requests to the CPU.
   output logic             breakForce,
   output logic             breakTag,
   // AXI4-Lite slave.
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      logic        enable;
      logic        arm;
      logic        cpu_break_enable;
      logic        tag;
      logic        loopMode;
      logic        engaged;
      logic [7:0]  trigSetup;
      logic [17:0] cmpA;
      logic [17:0] cmpB;
      logic [15:0] cmpC;
      logic [3:0]  count;
      logic [2:0]  wrPtr;
      logic [2:0]  rdPtr;
      logic        seenA;
      logic [2:0]  match;
      logic        inRange;
      logic        outRange;
      logic [15:0] prevAddr;
      track_t      trkA;
      track_t      trkB;
      run_t        run;
      logic        breakForce;
      logic        breakTag;
      logic        awHave;
      logic        wHave;
      logic [4:0]  awOfs;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        awReady;
      logic        wReady;
      logic        bValid;
      logic [1:0]  bResp;
      logic        arReady;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
   } state_t;

   state_t      st;
   state_t      next_st;
   logic [15:0] fifo [DEPTH];
   logic        fifoWr;
   logic [15:0] fifoWord;

   logic [3:0]  mode;
   logic        fullMode;
   logic        eventMode;
   logic        beginRun;
   logic        qualify;
   logic        dirEnSel;
   logic        dirSel;
   logic        qA;
   logic        qB;
   logic        trig;
   logic        cof;
   logic [15:0] cofAddr;
   logic        capture;
   logic        breakNow;
   logic        wrGo;
   logic        loopArm;

   // A direction-qualified cycle: with the enable off either direction passes.
   function automatic logic dirOk(input logic en, input logic dir, input logic wr);
      dirOk = !en || (wr == !dir);
   endfunction : dirOk

   assign mode      = st.trigSetup[3:0];
   assign fullMode  = (mode == `MODE_A_AND_B) || (mode == `MODE_A_NOT_B);
   assign eventMode = (mode == `MODE_EV_B) || (mode == `MODE_A_THEN_EVB);
   assign beginRun  = st.trigSetup[`TRG_BEGIN] || eventMode;
   assign qualify   = st.trigSetup[`TRG_QUALIFY] && !eventMode;
   // Full modes steer both comparators from A's direction bits only.
   assign dirEnSel  = st.cmpA[`CMP_DIR_EN];
   assign dirSel    = st.cmpA[`CMP_DIR];
   // Registered matches may be confirmed later by their own opcode tracker.
   assign qA        = qualify ? st.trkA.hit : st.match[0];
   assign qB        = qualify ? st.trkB.hit : st.match[1];
   assign cof       = busValid && (cofDest || cofBranch);
   assign cofAddr   = cofDest ? coreAddr : st.prevAddr - `BRANCH_BACK;
   assign wrGo      = st.awHave && st.wHave && !st.bValid;
   assign loopArm   = wrGo && st.awOfs == `OFS_CONTROL && st.wStrb[0] && st.wData[`CTL_ARM]
                      && st.wData[`CTL_ENABLE] && st.wData[`CTL_LOOP];

   always_comb begin
      unique case (mode)
         `MODE_A_ONLY:     trig = qA;
         `MODE_A_OR_B:     trig = qA || qB;
         `MODE_A_THEN_B:   trig = st.seenA && qB;
         `MODE_EV_B:       trig = st.match[1];
         `MODE_A_THEN_EVB: trig = st.seenA && st.match[1];
         `MODE_A_AND_B:    trig = qA && st.match[1];
         `MODE_A_NOT_B:    trig = qA && !st.match[1] && st.match[0];
         `MODE_INSIDE:     trig = st.inRange;
         `MODE_OUTSIDE:    trig = st.outRange;
         default:          trig = 1'b0;
      endcase
   end

   always_comb begin
      next_st = st;
      fifoWr   = 1'b0;
      fifoWord = eventMode ? {8'h00, (dirEnSel && !dirSel) ? writeData : readData} : cofAddr;
      capture  = 1'b0;
      breakNow = 1'b0;
      next_st.breakForce = 1'b0;
      next_st.breakTag   = 1'b0;
      if (busValid) begin
         next_st.prevAddr = coreAddr;
      end
      // Comparators, evaluated every cycle and registered.
      next_st.match[0] = busValid && coreAddr == st.cmpA[15:0]
                         && dirOk(st.cmpA[`CMP_DIR_EN], st.cmpA[`CMP_DIR], busWrite);
      if (fullMode) begin
         next_st.match[1] = busValid && (busWrite == (dirEnSel && !dirSel))
                            && (busWrite ? writeData : readData) == st.cmpB[7:0];
      end else begin
         next_st.match[1] = busValid && coreAddr == st.cmpB[15:0]
                            && dirOk(st.cmpB[`CMP_DIR_EN], st.cmpB[`CMP_DIR], busWrite);
      end
      next_st.match[2] = busValid && coreAddr == st.cmpC;
      next_st.inRange  = busValid && coreAddr >= st.cmpA[15:0] && coreAddr <= st.cmpB[15:0];
      next_st.outRange = busValid && (coreAddr < st.cmpA[15:0] || coreAddr > st.cmpB[15:0]);
      // Independent opcode trackers: a fetch match waits until that address executes.
      next_st.trkA.hit = st.trkA.pending && execValid && execAddr == st.cmpA[15:0];
      next_st.trkB.hit = st.trkB.pending && execValid && execAddr == st.cmpB[15:0];
      if (st.match[0]) next_st.trkA.pending = 1'b1;
      else if (st.trkA.hit) next_st.trkA.pending = 1'b0;
      if (st.match[1] && !fullMode) next_st.trkB.pending = 1'b1;
      else if (st.trkB.hit) next_st.trkB.pending = 1'b0;
      if (qA && st.run != RUN_IDLE) next_st.seenA = 1'b1;

      // Trigger break controller.
      unique case (st.run)
         RUN_IDLE: begin
         end
         RUN_WAIT: if (trig) begin
            next_st.run = RUN_BEGIN;
         end
         RUN_BEGIN: begin
            if (st.count == `FIFO_FULL_CNT) begin
               next_st.run = RUN_DONE;
               next_st.arm = 1'b0;
               breakNow    = 1'b1;
            end else begin
               capture = eventMode ? (trig || st.match[1]) : cof;
            end
         end
         RUN_END: begin
            if (trig) begin
               next_st.run = RUN_DONE;
               next_st.arm = 1'b0;
               breakNow    = 1'b1;
            end else begin
               capture = cof;
            end
         end
         RUN_DONE: begin
         end
         default: next_st.run = RUN_IDLE;
      endcase
      // Comparator C is a plain breakpoint unless loop mode is on; it tracks loop captures only outside the event modes.
      if (st.enable && !st.loopMode && st.match[2]) begin
         breakNow = 1'b1;
      end
      if (capture && st.loopMode && !eventMode) begin
         if (cofAddr == st.cmpC) begin
            capture = 1'b0;
         end else begin
            next_st.cmpC = cofAddr;
         end
      end
      if (capture) begin
         fifoWr = 1'b1;
         next_st.wrPtr = st.wrPtr + 3'h1;
         if (st.count != `FIFO_FULL_CNT) next_st.count = st.count + 4'h1;
      end
      if (breakNow && st.cpu_break_enable) begin
         next_st.breakForce = !st.tag;
         next_st.breakTag   = st.tag;
      end
      if (next_st.run == RUN_DONE && st.run != RUN_DONE) begin
         next_st.rdPtr = next_st.wrPtr - next_st.count[2:0];
      end

      // AXI4-Lite write channel.
      if (s_axi_awvalid && st.awReady) begin
         next_st.awHave = 1'b1;
         next_st.awOfs  = s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && st.wReady) begin
         next_st.wHave = 1'b1;
         next_st.wData = s_axi_wdata;
         next_st.wStrb = s_axi_wstrb;
      end
      if (wrGo) begin
         next_st.awHave = 1'b0;
         next_st.wHave  = 1'b0;
         next_st.bValid = 1'b1;
         next_st.bResp  = `RESP_OKAY;
         unique case (st.awOfs)
            `OFS_CONTROL: if (st.wStrb[0]) begin
               next_st.enable   = st.wData[`CTL_ENABLE];
               next_st.arm      = st.wData[`CTL_ARM];
               next_st.cpu_break_enable    = st.wData[`CTL_BRK_EN];
               next_st.tag      = st.wData[`CTL_TAG];
               next_st.loopMode = st.wData[`CTL_LOOP];
               if (st.wData[`CTL_ARM] && st.wData[`CTL_ENABLE]) begin
                  next_st.count   = 4'h0;
                  next_st.wrPtr   = 3'h0;
                  next_st.seenA   = 1'b0;
                  next_st.engaged = 1'b1;
                  next_st.run     = beginRun ? RUN_WAIT : RUN_END;
                  if (st.wData[`CTL_LOOP]) next_st.cmpC = 16'h0000;
               end
            end
            `OFS_TRIGGER: if (st.wStrb[0]) next_st.trigSetup = st.wData[7:0];
            `OFS_CMP_A:   next_st.cmpA = st.wData[17:0];
            `OFS_CMP_B:   next_st.cmpB = st.wData[17:0];
            `OFS_CMP_C:   next_st.cmpC = st.wData[15:0];
            default:      next_st.bResp = `RESP_SLVERR;
         endcase
      end
      if (st.bValid && s_axi_bready) next_st.bValid = 1'b0;
      next_st.awReady = !next_st.awHave && !next_st.bValid;
      next_st.wReady  = !next_st.wHave && !next_st.bValid;

      // AXI4-Lite read channel; reading the trace word walks to the next oldest entry.
      if (s_axi_arvalid && st.arReady) begin
         next_st.rValid = 1'b1;
         next_st.rResp  = `RESP_OKAY;
         next_st.rData  = 32'h0000_0000;
         unique case (s_axi_araddr[4:0])
            `OFS_CONTROL: begin
               next_st.rData[4:0] = {st.loopMode, st.tag, st.cpu_break_enable, st.arm, st.enable};
               next_st.rData[`STS_ENGAGED] = st.engaged;
               next_st.rData[`STS_COUNT_LSB +: 4] = st.count;
            end
            `OFS_TRIGGER: next_st.rData[7:0]  = st.trigSetup;
            `OFS_CMP_A:   next_st.rData[17:0] = st.cmpA;
            `OFS_CMP_B:   next_st.rData[17:0] = st.cmpB;
            `OFS_CMP_C:   next_st.rData[15:0] = st.cmpC;
            `OFS_FIFO: begin
               next_st.rData[15:0] = fifo[st.rdPtr];
               next_st.rdPtr = st.rdPtr + 3'h1;
            end
            default: next_st.rResp = `RESP_SLVERR;
         endcase
      end
      if (st.rValid && s_axi_rready) next_st.rValid = 1'b0;
      next_st.arReady = !next_st.rValid;

      // Disabling stops the run and trace writes, including a pending arm.
      if (!next_st.enable) begin
         next_st.arm = 1'b0;
         next_st.run = RUN_IDLE;
         fifoWr      = 1'b0;
      end
      if (!next_st.arm) begin
         next_st.engaged = 1'b0;
         if (next_st.run != RUN_DONE) next_st.run = RUN_IDLE;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.run <= RUN_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Trace storage carries no reset; the count says how much of it is valid.
   always_ff @(posedge ref_clk) begin
      if (fifoWr) begin
         fifo[st.wrPtr] <= fifoWord;
      end
   end

   assign breakForce    = st.breakForce;
   assign breakTag      = st.breakTag;
   assign s_axi_awready = st.awReady;
   assign s_axi_wready  = st.wReady;
   assign s_axi_bvalid  = st.bValid;
   assign s_axi_bresp   = st.bResp;
   assign s_axi_arready = st.arReady;
   assign s_axi_rvalid  = st.rValid;
   assign s_axi_rdata   = st.rData;
   assign s_axi_rresp   = st.rResp;

   no_break_disabled_a: assert property (@(posedge ref_clk) disable iff (reset)
      !st.cpu_break_enable |=> !breakForce && !breakTag)
      else $error("Break request issued while breaks disabled.");
   no_run_disabled_a: assert property (@(posedge ref_clk) disable iff (reset)
      !st.enable |-> st.run == RUN_IDLE && !fifoWr)
      else $error("Trace active while module disabled.");
   count_saturates_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.count <= `FIFO_FULL_CNT)
      else $error("Word count passed eight.");
   count_steps_a: assert property (@(posedge ref_clk) disable iff (reset)
      fifoWr && st.count < `FIFO_FULL_CNT && !wrGo |=> st.count == $past(st.count) + 4'h1)
      else $error("Word count missed a capture.");
   end_break_same_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.run == RUN_END && trig && st.cpu_break_enable && st.enable |=> breakForce || breakTag)
      else $error("End trigger did not raise the break.");
   begin_break_full_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.run == RUN_BEGIN && st.count != `FIFO_FULL_CNT && !st.match[2] |=> !breakForce && !breakTag)
      else $error("Begin run broke before full.");
   break_kind_a: assert property (@(posedge ref_clk) disable iff (reset)
      !(breakForce && breakTag))
      else $error("Force and tag requests together.");
   end_stops_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.run == RUN_END && trig && st.enable |-> !fifoWr ##1 !st.arm && !st.engaged)
      else $error("End trigger did not stop capture.");
   loop_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      loopArm |=> st.cmpC == 16'h0000)
      else $error("Loop arming did not clear comparator C.");
   wait_no_store_a: assert property (@(posedge ref_clk) disable iff (reset)
      st.run == RUN_WAIT |-> !fifoWr)
      else $error("Begin run stored before trigger.");
endmodule : trace_trigger_break_control
`default_nettype wire

// ===== trace_trigger_break_control_tb.sv
// Self-checking bench for the trace trigger break controller.
// Assumes the design package, constants header and CPU model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module trace_trigger_break_control_tb;
   typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
   logic        ref_clk = 1'h0, reset = 1'h1, cycValid = 1'h0, cycCof = 1'h0;
   logic [15:0] cycAddr = 16'h0, coreAddr, execAddr;
   logic [7:0]  readData;
   logic        busValid, cofDest, execValid, breakForce, breakTag;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   int          forceSeen, tagSeen, f0 = 0, t0 = 0, errCount = 0, checksDone = 0, cycles = 0;
   logic [15:0] la [4] = '{16'h1000, 16'h1100, 16'h1100, 16'h1200};
   row_t        rows [5] = '{'{32'h04, 32'h01, 32'h01, 2'h0}, '{32'h08, 32'h4000, 32'h4000, 2'h0},
      '{32'h0C, 32'h7777, 32'h7777, 2'h0}, '{32'h10, 32'h5555, 32'h5555, 2'h0}, '{32'h18, 32'hFFFF, 32'h0, 2'h2}};
   trace_trigger_break_control #(.DEPTH(8)) i_trace_trigger_break_control (.ref_clk(ref_clk), .reset(reset),
      .busValid(busValid), .busWrite(1'h0), .coreAddr(coreAddr), .readData(readData), .writeData(8'h00),
      .cofDest(cofDest), .cofBranch(1'h0), .execValid(execValid), .execAddr(execAddr),
      .breakForce(breakForce), .breakTag(breakTag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cpu_bus_model i_cpu_bus_model (.ref_clk(ref_clk), .reset(reset), .cycValid(cycValid), .cycAddr(cycAddr),
      .cycCof(cycCof), .busValid(busValid), .coreAddr(coreAddr), .readData(readData), .cofDest(cofDest),
      .execValid(execValid), .execAddr(execAddr), .breakForce(breakForce), .breakTag(breakTag),
      .forceSeen(forceSeen),
      .tagSeen(tagSeen));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic conclude();
      if (errCount == 0 && checksDone > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bready && bvalid) begin
            resp = bresp; bready <= 1'h0;
         end
      end while (awvalid | wvalid | bready);
   endtask : wr
   task automatic rdr(input logic [31:0] a);
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rready && rvalid) begin
            rd = rdata; resp = rresp; rready <= 1'h0;
         end
      end while (arvalid | rready);
   endtask : rdr
   task automatic cyc(input logic [15:0] a, input logic c);
      cycValid <= 1'h1; cycAddr <= a; cycCof <= c;
      @(posedge ref_clk);
   endtask : cyc
   task automatic idle(input int n);
      cycValid <= 1'h0; cycCof <= 1'h0;
      repeat (n) @(posedge ref_clk);
   endtask : idle
   task automatic brk(input int ef, input int et);
      chk(32'(forceSeen - f0), 32'(ef));
      chk(32'(tagSeen - t0), 32'(et));
      f0 = forceSeen; t0 = tagSeen;
   endtask : brk
   task automatic status(input logic [3:0] n, input logic e);
      rdr(32'h0);
      chk(32'({rd[15:12], rd[8]}), 32'({n, e}));
   endtask : status
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errCount++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      chk(32'({awready, wready, arready, bvalid, rvalid, breakForce, breakTag}), 32'h0);
      reset <= 1'h0;
      repeat (2) @(posedge ref_clk);
      status(4'h0, 1'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(32'(resp), 32'(rows[i].r));
         rdr(rows[i].a);
         chk(rd, rows[i].e);
         chk(32'(resp), 32'(rows[i].r));
      end
      // End run on A or B with force and tag breaks, then the disabled cases and a C breakpoint; captures after the trigger must be dropped.
      wr(32'h0, 32'h07);
      foreach (la[i]) begin
         cyc(la[i], 1'h1); idle(2);
      end
      cyc(16'h4000, 1'h0); idle(4); brk(1, 0);
      cyc(16'h1300, 1'h1); idle(2); status(4'h4, 1'h0);
      foreach (la[i]) begin
         rdr(32'h14); chk(32'(rd[15:0]), 32'(la[i]));
      end
      wr(32'h04, 32'h81); wr(32'h0, 32'h0F); cyc(16'h7777, 1'h0); idle(7); brk(0, 1);
      wr(32'h0, 32'h03); cyc(16'h4000, 1'h0); idle(5); brk(0, 0);
      wr(32'h0, 32'h0E); cyc(16'h4000, 1'h0); idle(5); brk(0, 0);
      wr(32'h0, 32'h05); cyc(16'h5555, 1'h0); idle(5); brk(1, 0);
      // Begin run: nothing stored before the trigger, break only once eight words are held.
      wr(32'h04, 32'h41); wr(32'h0, 32'h07);
      cyc(16'h1000, 1'h1); idle(2); cyc(16'h4000, 1'h0); idle(3);
      for (int i = 0; i < 9; i++) begin
         if (i == 7) brk(0, 0);
         cyc(16'h2000 + 16'(i), 1'h1); idle(2);
      end
      idle(3); brk(1, 0); status(4'h8, 1'h0);
      rdr(32'h14); chk(32'(rd[15:0]), 32'h2000);
      // Loop capture: duplicate change-of-flow addresses are skipped and C tracks the last one.
      wr(32'h04, 32'h01); wr(32'h0, 32'h13);
      foreach (la[i]) begin
         cyc(la[i], 1'h1); idle(2);
      end
      status(4'h3, 1'h1);
      rdr(32'h10); chk(32'(rd[15:0]), 32'h1200);
      conclude();
   end
endmodule : trace_trigger_break_control_tb
`default_nettype wire

// ===== trace_trigger_consts.svh
// Offsets, field positions, codes and counts for the trace trigger break controller.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TRACE_TRIGGER_CONSTS_SVH
`define TRACE_TRIGGER_CONSTS_SVH
`define OFS_CONTROL     5'h00
`define OFS_TRIGGER     5'h04
`define OFS_CMP_A       5'h08
`define OFS_CMP_B       5'h0C
`define OFS_CMP_C       5'h10
`define OFS_FIFO        5'h14
`define CTL_ENABLE      0
`define CTL_ARM         1
`define CTL_BRK_EN      2
`define CTL_TAG         3
`define CTL_LOOP        4
`define STS_ENGAGED     8
`define STS_COUNT_LSB   12
`define TRG_BEGIN       6
`define TRG_QUALIFY     7
`define CMP_DIR         16
`define CMP_DIR_EN      17
`define MODE_A_ONLY     4'h0
`define MODE_A_OR_B     4'h1
`define MODE_A_THEN_B   4'h2
`define MODE_EV_B       4'h3
`define MODE_A_THEN_EVB 4'h4
`define MODE_A_AND_B    4'h5
`define MODE_A_NOT_B    4'h6
`define MODE_INSIDE     4'h7
`define MODE_OUTSIDE    4'h8
`define FIFO_FULL_CNT   4'h8
`define BRANCH_BACK     16'h0002
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ===== trace_trigger_pkg.sv
// Types shared by the trace trigger break controller.
// Assumes the constants header sits in the same folder.
`include "trace_trigger_consts.svh"
package trace_trigger_pkg;
   typedef enum logic [4:0] {
      RUN_IDLE  = 5'b00001,
      RUN_WAIT  = 5'b00010,
      RUN_BEGIN = 5'b00100,
      RUN_END   = 5'b01000,
      RUN_DONE  = 5'b10000
   } run_t;
   typedef struct packed {
      logic        pending;
      logic        hit;
   } track_t;
endpackage : trace_trigger_pkg
